// >>> hw/vph_defines.svh
// constants for the video processor host port: field positions, widths, reset values, timing
// assumes a single 40 MHz clock; included by bare name from every design file but the package
`ifndef VPH_DEFINES_SVH
`define VPH_DEFINES_SVH

// ==========================================================
// widths
`define VPH_DATA_W        8
`define VPH_ADDR_W        14
`define VPH_NUM_REGS      8
`define VPH_REG_IDX_W     3
`define VPH_ADDR_HI_W     6
`define VPH_SPR_NUM_W     5

// ==========================================================
// second control byte decode
`define VPH_CMD_REG_BIT   7
`define VPH_CMD_WR_BIT    6

// ==========================================================
// control register 1 fields, lsb-weighted (msb-first bit 1 and bit 2)
`define VPH_BLANK_BIT     6
`define VPH_IE_BIT        5

// ==========================================================
// status register fields
`define VPH_ST_FRAME      7
`define VPH_ST_FIFTH      6
`define VPH_ST_COINC      5

// ==========================================================
// pin synchroniser lanes: write strobe, read strobe, port select, data
`define VPH_SYN_W         11
`define VPH_SYN_WR        10
`define VPH_SYN_RD        9
`define VPH_SYN_SEL       8
`define VPH_SYN_RST       11'h600

// ==========================================================
// timing
`define VPH_CLK_MHZ       40
`define VPH_RESET_MIN_NS  3000
`define VPH_RESET_MIN_CYC ((`VPH_RESET_MIN_NS * `VPH_CLK_MHZ + 999) / 1000)

`endif

// >>> hw/vph_pkg.sv
// types shared by the video processor host port modules
// assumes vph_defines.svh is on the include path
package vph_pkg;
	typedef enum logic [1:0] {
		VPH_MEM_IDLE,
		VPH_MEM_READ,
		VPH_MEM_WRITE
	} vph_mem_state_t;
endpackage

// >>> hw/vph_strobe_if.sv
// carrier between the pin synchroniser and the port logic
// assumes both ends run on the same clock
`timescale 1ns/1ps
`include "vph_defines.svh"
interface vph_strobe_if;
	logic                   wr_evt;
	logic                   rd_evt;
	logic                   rd_level_n;
	logic                   sel;
	logic [`VPH_DATA_W-1:0] data;

	modport src (output wr_evt, output rd_evt, output rd_level_n, output sel, output data);
	modport dst (input wr_evt, input rd_evt, input rd_level_n, input sel, input data);
endinterface

// >>> hw/vph_strobe_sync.sv
// three-flop synchroniser for the host port pins, with strobe fall detection
// assumes host pins are asynchronous to clk; a change counts once stages two and three agree
`timescale 1ns/1ps
`include "vph_defines.svh"
module vph_strobe_sync
	import vph_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  wire logic                   write_strobe_n,
	input  wire logic                   read_strobe_n,
	input  wire logic                   port_select,
	input  wire logic [`VPH_DATA_W-1:0] host_data_in,
	vph_strobe_if.src                   bus
);
	logic [`VPH_SYN_W-1:0] pins;
	logic [`VPH_SYN_W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
	logic                  wr_evt_q, wr_evt_d, rd_evt_q, rd_evt_d;

	assign pins = {write_strobe_n, read_strobe_n, port_select, host_data_in};

	// ==========================================================
	// agreement filter per lane
	genvar i;
	generate
		for (i = 0; i < `VPH_SYN_W; i++) begin : g_lane
			always_comb begin
				lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
			end
		end
	endgenerate

	always_comb begin
		wr_evt_d = lvl_q[`VPH_SYN_WR] & ~lvl_d[`VPH_SYN_WR];
		rd_evt_d = lvl_q[`VPH_SYN_RD] & ~lvl_d[`VPH_SYN_RD];
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s1_q     <= `VPH_SYN_RST;
			s2_q     <= `VPH_SYN_RST;
			s3_q     <= `VPH_SYN_RST;
			lvl_q    <= `VPH_SYN_RST;
			wr_evt_q <= 1'b0;
			rd_evt_q <= 1'b0;
		end else begin
			s1_q     <= pins;
			s2_q     <= s1_q;
			s3_q     <= s2_q;
			lvl_q    <= lvl_d;
			wr_evt_q <= wr_evt_d;
			rd_evt_q <= rd_evt_d;
		end
	end

	// select and data settle with the strobe lane, so they line up with the event
	assign bus.wr_evt     = wr_evt_q;
	assign bus.rd_evt     = rd_evt_q;
	assign bus.rd_level_n = lvl_q[`VPH_SYN_RD];
	assign bus.sel        = lvl_q[`VPH_SYN_SEL];
	assign bus.data       = lvl_q[`VPH_DATA_W-1:0];

	a_evt_single : assert property (@(posedge clk) disable iff (!reset_n)
		wr_evt_q |=> !wr_evt_q) else $error("write event longer than one cycle");
endmodule

// >>> hw/vph_host_port.sv
// host port of the video processor: control pairing, register load, address, memory streaming, status
// assumes a video memory that answers each request with a one-cycle ack on clk, and a scan engine
// that pulses frame_end, sprite_coinc_evt and fifth_sprite_evt on clk
`timescale 1ns/1ps
`include "vph_defines.svh"
module vph_host_port
	import vph_pkg::*;
#(
	parameter int ADDR_W   = `VPH_ADDR_W,
	parameter int NUM_REGS = `VPH_NUM_REGS
)(
	input  wire logic                                 clk,
	input  wire logic                                 reset_n,
	input  wire logic                                 write_strobe_n,
	input  wire logic                                 read_strobe_n,
	input  wire logic                                 port_select,
	input  wire logic [`VPH_DATA_W-1:0]               host_data_in,
	output logic      [`VPH_DATA_W-1:0]               host_data_out_q,
	output logic                                      host_data_oe_q,
	output logic                                      irq_n_q,
	output logic                                      vmem_req_q,
	output logic                                      vmem_we_q,
	output logic      [ADDR_W-1:0]                    vmem_addr_q,
	output logic      [`VPH_DATA_W-1:0]               vmem_wdata_q,
	input  wire logic                                 vmem_ack,
	input  wire logic [`VPH_DATA_W-1:0]               vmem_rdata,
	input  wire logic                                 frame_end,
	input  wire logic                                 sprite_coinc_evt,
	input  wire logic                                 fifth_sprite_evt,
	input  wire logic [`VPH_SPR_NUM_W-1:0]            fifth_sprite_num,
	output logic      [NUM_REGS-1:0][`VPH_DATA_W-1:0] ctrl_regs_q,
	output logic                                      border_only_q,
	output logic                                      refresh_en_q
);
	vph_strobe_if bus ();

	vph_strobe_sync u_sync (
		.clk            (clk),
		.reset_n        (reset_n),
		.write_strobe_n (write_strobe_n),
		.read_strobe_n  (read_strobe_n),
		.port_select    (port_select),
		.host_data_in   (host_data_in),
		.bus            (bus.src)
	);

	// ==========================================================
	// address assembly, shared by register loads and address setup
	function automatic logic [ADDR_W-1:0] join_addr(input logic [`VPH_DATA_W-1:0] hi,
	                                                input logic [`VPH_DATA_W-1:0] lo);
		join_addr = ADDR_W'({hi[`VPH_ADDR_HI_W-1:0], lo});
	endfunction

	// ==========================================================
	// state
	logic [NUM_REGS-1:0][`VPH_DATA_W-1:0] ctrl_d;
	logic                                 second_q, second_d;
	logic [`VPH_DATA_W-1:0]               latch_q, latch_d;
	logic [ADDR_W-1:0]                    addr_q, addr_d;
	logic [`VPH_DATA_W-1:0]               rd_buf_q, rd_buf_d;
	logic [`VPH_DATA_W-1:0]               out_d;
	logic                                 oe_d, irq_n_d, border_d;
	logic                                 frame_q, frame_d;
	logic                                 coinc_q, coinc_d;
	logic                                 fifth_q, fifth_d;
	logic [`VPH_SPR_NUM_W-1:0]            fnum_q, fnum_d;
	vph_mem_state_t                       mem_q, mem_d;
	logic                                 req_d, we_d;
	logic [ADDR_W-1:0]                    maddr_d;
	logic [`VPH_DATA_W-1:0]               wdata_d;
	logic [`VPH_DATA_W-1:0]               status;
	logic                                 wr_ctl, wr_dat, rd_ctl, rd_dat;

	assign wr_ctl = bus.wr_evt & bus.sel;
	assign wr_dat = bus.wr_evt & ~bus.sel;
	assign rd_ctl = bus.rd_evt & bus.sel;
	assign rd_dat = bus.rd_evt & ~bus.sel;
	assign status = {frame_q, fifth_q, coinc_q, fnum_q};

	// ==========================================================
	// next-state logic
	always_comb begin
		ctrl_d   = ctrl_regs_q;
		second_d = second_q;
		latch_d  = latch_q;
		addr_d   = addr_q;
		rd_buf_d = rd_buf_q;
		out_d    = host_data_out_q;
		mem_d    = mem_q;
		req_d    = vmem_req_q;
		we_d     = vmem_we_q;
		maddr_d  = vmem_addr_q;
		wdata_d  = vmem_wdata_q;
		frame_d  = frame_q;
		coinc_d  = coinc_q;
		fifth_d  = fifth_q;
		fnum_d   = fnum_q;

		// memory completion first, so a new request in the same cycle replaces it
		if (vmem_req_q && vmem_ack) begin
			if (mem_q == VPH_MEM_READ)
				rd_buf_d = vmem_rdata;
			req_d = 1'b0;
			mem_d = VPH_MEM_IDLE;
		end

		// control port writes: two-byte pairing
		if (wr_ctl) begin
			if (!second_q) begin
				latch_d  = bus.data;
				second_d = 1'b1;
			end else begin
				second_d = 1'b0;
				// a register load also rewrites the address, as the hardware does
				addr_d = join_addr(bus.data, latch_q);
				if (bus.data[`VPH_CMD_REG_BIT]) begin
					ctrl_d[bus.data[`VPH_REG_IDX_W-1:0]] = latch_q;
				end else if (!bus.data[`VPH_CMD_WR_BIT]) begin
					// read setup: fetch now so the first data read has its byte
					mem_d   = VPH_MEM_READ;
					req_d   = 1'b1;
					we_d    = 1'b0;
					maddr_d = join_addr(bus.data, latch_q);
					addr_d  = join_addr(bus.data, latch_q) + 1'b1;
				end
				// 01 is write setup: nothing to fetch, data writes follow
			end
		end

		// data port write
		if (wr_dat) begin
			mem_d    = VPH_MEM_WRITE;
			req_d    = 1'b1;
			we_d     = 1'b1;
			maddr_d  = addr_q;
			wdata_d  = bus.data;
			addr_d   = addr_q + 1'b1;
			second_d = 1'b0;
		end

		// data port read: hand out the prefetched byte, fetch the next
		if (rd_dat) begin
			out_d    = rd_buf_q;
			addr_d   = addr_q + 1'b1;
			second_d = 1'b0;
			// a colliding write keeps the memory cycle, so the junk byte still lands; no prefetch then
			if (!wr_dat) begin
				mem_d   = VPH_MEM_READ;
				req_d   = 1'b1;
				we_d    = 1'b0;
				maddr_d = addr_q;
			end
		end

		// status read: answer, clear flags, restart pairing
		if (rd_ctl) begin
			out_d    = status;
			frame_d  = 1'b0;
			coinc_d  = 1'b0;
			fifth_d  = 1'b0;
			second_d = 1'b0;
		end

		// scan events come last so a frame or coincidence set in the clearing cycle is kept
		if (frame_end)
			frame_d = 1'b1;
		if (sprite_coinc_evt)
			coinc_d = 1'b1;
		if (fifth_sprite_evt && !fifth_q) begin
			fifth_d = 1'b1;
			fnum_d  = fifth_sprite_num;
		end

		// both strobes low is tolerated: drive and write happen together
		oe_d     = ~bus.rd_level_n;
		irq_n_d  = ~(ctrl_d[1][`VPH_IE_BIT] & frame_d);
		border_d = ~ctrl_d[1][`VPH_BLANK_BIT];
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_regs_q     <= '0;
			second_q        <= 1'b0;
			latch_q         <= 8'h00;
			addr_q          <= '0;
			rd_buf_q        <= 8'h00;
			host_data_out_q <= 8'h00;
			host_data_oe_q  <= 1'b0;
			irq_n_q         <= 1'b1;
			border_only_q   <= 1'b1;
			refresh_en_q    <= 1'b0;
			frame_q         <= 1'b0;
			coinc_q         <= 1'b0;
			fifth_q         <= 1'b0;
			fnum_q          <= 5'h00;
			mem_q           <= VPH_MEM_IDLE;
			vmem_req_q      <= 1'b0;
			vmem_we_q       <= 1'b0;
			vmem_addr_q     <= '0;
			vmem_wdata_q    <= 8'h00;
		end else begin
			ctrl_regs_q     <= ctrl_d;
			second_q        <= second_d;
			latch_q         <= latch_d;
			addr_q          <= addr_d;
			rd_buf_q        <= rd_buf_d;
			host_data_out_q <= out_d;
			host_data_oe_q  <= oe_d;
			irq_n_q         <= irq_n_d;
			border_only_q   <= border_d;
			// refresh is never gated by blanking
			refresh_en_q    <= 1'b1;
			frame_q         <= frame_d;
			coinc_q         <= coinc_d;
			fifth_q         <= fifth_d;
			fnum_q          <= fnum_d;
			mem_q           <= mem_d;
			vmem_req_q      <= req_d;
			vmem_we_q       <= we_d;
			vmem_addr_q     <= maddr_d;
			vmem_wdata_q    <= wdata_d;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_write_capture : assert property (
		wr_dat |=> vmem_req_q && vmem_we_q && vmem_wdata_q == $past(bus.data))
		else $error("data write not passed to memory");
	a_read_drive : assert property (
		!bus.rd_level_n |=> host_data_oe_q)
		else $error("data lines not driven during read");
	a_both_strobes : assert property (
		(wr_dat && rd_dat) |=> host_data_out_q == $past(rd_buf_q) && vmem_req_q)
		else $error("collision did not both drive and write");
	a_pair_restart : assert property (
		(rd_ctl || wr_dat || rd_dat) && !wr_ctl |=> !second_q)
		else $error("pairing not restarted");
	a_reg_load : assert property (
		wr_ctl && second_q && bus.data[7] |=>
		ctrl_regs_q[$past(bus.data[2:0])] == $past(latch_q) && addr_q == join_addr($past(bus.data), $past(latch_q)))
		else $error("register load wrong");
	a_read_setup : assert property (
		wr_ctl && second_q && bus.data[7:6] == 2'b00 |=>
		vmem_req_q && !vmem_we_q && addr_q == vmem_addr_q + 1'b1)
		else $error("read setup did not prefetch");
	a_addr_incr : assert property (
		(wr_dat || rd_dat) && !wr_ctl |=> addr_q == $past(addr_q) + 1'b1)
		else $error("address not incremented");
	a_status_read : assert property (
		rd_ctl |=> host_data_out_q == $past(status))
		else $error("status not returned");
	a_frame_clear : assert property (
		rd_ctl && !frame_end |=> !frame_q && irq_n_q)
		else $error("frame flag not cleared by status read");
	a_frame_set : assert property (
		frame_end |=> frame_q)
		else $error("frame flag not set");
	a_irq_gate : assert property (
		!irq_n_q |-> ctrl_regs_q[1][`VPH_IE_BIT] && frame_q)
		else $error("interrupt without enable and flag");

	c_reg_load   : cover property (wr_ctl && second_q && bus.data[7]);
	c_vmem_write : cover property (wr_dat ##[1:400] vmem_ack);
	c_vmem_read  : cover property (rd_dat ##[1:400] (vmem_ack && mem_q == VPH_MEM_READ));
	c_irq        : cover property (!irq_n_q ##[1:50] rd_ctl);
endmodule

// >>> tb/vph_vmem_model.sv
// video memory model that answers the host port's memory requests
// assumes req is held until ack; ack is a one-cycle pulse and rdata is only valid with it
`timescale 1ns/1ps
module vph_vmem_model (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [3:0]  lat,
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [13:0] addr,
	input  wire logic [7:0]  wdata,
	output logic             ack,
	output logic      [7:0]  rdata
);
	logic [7:0] mem [0:16383];
	logic [3:0] wait_q;

	// ==========================================================
	// answer after lat idle cycles; rdata toggles outside ack so stale data never looks valid
	initial begin
		ack = 1'b0;
		rdata = 8'h00;
		wait_q = 4'h0;
	end

	always @(posedge clk) begin
		ack <= 1'b0;
		rdata <= ~rdata;
		if (!reset_n) begin
			wait_q <= 4'h0;
		end else if (req && !ack) begin
			if (wait_q >= lat) begin
				ack <= 1'b1;
				wait_q <= 4'h0;
				rdata <= mem[addr];
				if (we) begin
					mem[addr] <= wdata;
				end
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule

// >>> tb/vph_host_port_tb.sv
// self-checking bench for the video processor host port
// assumes the memory model answers requests; host pins are driven on the falling clock edge
`timescale 1ns/1ps
`include "vph_defines.svh"
module vph_host_port_tb;
	logic                                      clk;
	logic                                      reset_n;
	logic                                      write_strobe_n;
	logic                                      read_strobe_n;
	logic                                      port_select;
	logic [`VPH_DATA_W-1:0]                    host_data_in;
	logic [`VPH_DATA_W-1:0]                    host_data_out_q;
	logic                                      host_data_oe_q;
	logic                                      irq_n_q;
	logic                                      vmem_req_q;
	logic                                      vmem_we_q;
	logic [13:0]                               vmem_addr_q;
	logic [`VPH_DATA_W-1:0]                    vmem_wdata_q;
	logic                                      vmem_ack;
	logic [`VPH_DATA_W-1:0]                    vmem_rdata;
	logic                                      frame_end;
	logic                                      sprite_coinc_evt;
	logic                                      fifth_sprite_evt;
	logic [4:0]                                fifth_sprite_num;
	logic [`VPH_NUM_REGS-1:0][`VPH_DATA_W-1:0] ctrl_regs_q;
	logic                                      border_only_q;
	logic                                      refresh_en_q;
	logic [3:0]                                lat;
	logic [7:0]                                q;
	int                                        n_errors;
	int                                        n_compared;
	int                                        cyc;

	vph_host_port vph_host_port_inst (.clk(clk), .reset_n(reset_n), .write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n), .port_select(port_select), .host_data_in(host_data_in),
		.host_data_out_q(host_data_out_q), .host_data_oe_q(host_data_oe_q), .irq_n_q(irq_n_q),
		.vmem_req_q(vmem_req_q), .vmem_we_q(vmem_we_q), .vmem_addr_q(vmem_addr_q),
		.vmem_wdata_q(vmem_wdata_q), .vmem_ack(vmem_ack), .vmem_rdata(vmem_rdata), .frame_end(frame_end),
		.sprite_coinc_evt(sprite_coinc_evt), .fifth_sprite_evt(fifth_sprite_evt),
		.fifth_sprite_num(fifth_sprite_num), .ctrl_regs_q(ctrl_regs_q), .border_only_q(border_only_q),
		.refresh_en_q(refresh_en_q));

	vph_vmem_model vph_vmem_model_inst (.clk(clk), .reset_n(reset_n), .lat(lat), .req(vmem_req_q),
		.we(vmem_we_q), .addr(vmem_addr_q), .wdata(vmem_wdata_q), .ack(vmem_ack), .rdata(vmem_rdata));

	// ==========================================================
	// clock, watchdog, reporting
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// ==========================================================
	// host transfers: setup three cycles, strobe low eight, high eight, so the synchroniser sees each edge
	task automatic xfer(input logic sel, input logic rd, input logic [7:0] d, output logic [7:0] r);
		@(negedge clk);
		port_select = sel;
		host_data_in = d;
		repeat (3) @(negedge clk);
		if (rd) read_strobe_n = 1'b0;
		else write_strobe_n = 1'b0;
		repeat (8) @(negedge clk);
		r = host_data_out_q;
		if (rd) chk(16'(host_data_oe_q), 16'h0001);
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		repeat (8) @(negedge clk);
		if (rd) chk(16'(host_data_oe_q), 16'h0000);
		if (!sel) repeat (320) @(negedge clk);
	endtask

	task automatic wr(input logic sel, input logic [7:0] d);
		logic [7:0] r;
		xfer(sel, 1'b0, d, r);
	endtask

	task automatic set_addr(input logic [13:0] a, input logic wmode);
		wr(1'b1, a[7:0]);
		wr(1'b1, {1'b0, wmode, a[13:8]});
		if (!wmode) repeat (120) @(negedge clk);
	endtask

	task automatic ev(input logic [2:0] m);
		@(negedge clk);
		{frame_end, sprite_coinc_evt, fifth_sprite_evt} = m;
		@(negedge clk);
		{frame_end, sprite_coinc_evt, fifth_sprite_evt} = 3'h0;
		repeat (2) @(negedge clk);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		for (int i = 0; i < 8; i++) chk(16'(ctrl_regs_q[i]), 16'h0000);
		chk(16'(border_only_q), 16'h0001);
		chk(16'(refresh_en_q), 16'h0001);
		chk(16'(irq_n_q), 16'h0001);
		$display("test reset done");
	endtask

	task automatic t_regs();
		for (int i = 0; i < 8; i++) begin
			wr(1'b1, 8'hA0 + 8'(i));
			wr(1'b1, {5'b10000, 3'(i)});
			chk(16'(ctrl_regs_q[i]), 16'(8'hA0 + 8'(i)));
		end
		// last load leaves the address at {07, A7}
		wr(1'b0, 8'h5A);
		chk(16'(vph_vmem_model_inst.mem[14'h07A7]), 16'h005A);
		@(negedge clk);
		reset_n = 1'b0;
		repeat (`VPH_RESET_MIN_CYC) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		chk({ctrl_regs_q[1], ctrl_regs_q[0]}, 16'h0000);
		$display("test register load done");
	endtask

	task automatic t_irq();
		wr(1'b1, 8'h20);
		wr(1'b1, 8'h81);
		chk(16'(border_only_q), 16'h0001);
		ev(3'b100);
		chk(16'(irq_n_q), 16'h0000);
		xfer(1'b1, 1'b1, 8'h00, q);
		chk(16'(q), 16'h0080);
		chk(16'(irq_n_q), 16'h0001);
		fifth_sprite_num = 5'h0B;
		ev(3'b011);
		chk(16'(irq_n_q), 16'h0001);
		xfer(1'b1, 1'b1, 8'h00, q);
		chk(16'(q), 16'h006B);
		wr(1'b1, 8'h40);
		wr(1'b1, 8'h81);
		chk(16'(border_only_q), 16'h0000);
		ev(3'b100);
		chk(16'(irq_n_q), 16'h0001);
		xfer(1'b1, 1'b1, 8'h00, q);
		chk(16'(q & 8'hE0), 16'h0080);
		$display("test status and interrupt done");
	endtask

	task automatic t_pair();
		// a lone first byte followed by a status read must not pair with the next byte
		wr(1'b1, 8'h55);
		xfer(1'b1, 1'b1, 8'h00, q);
		wr(1'b1, 8'h33);
		wr(1'b1, 8'h82);
		chk(16'(ctrl_regs_q[2]), 16'h0033);
		wr(1'b1, 8'h11);
		wr(1'b0, 8'h99);
		wr(1'b1, 8'h44);
		wr(1'b1, 8'h83);
		chk(16'(ctrl_regs_q[3]), 16'h0044);
		$display("test pairing done");
	endtask

	task automatic t_stream();
		set_addr(14'h3FFE, 1'b1);
		for (int k = 0; k < 3; k++) wr(1'b0, 8'hC0 + 8'(k));
		chk(16'(vph_vmem_model_inst.mem[14'h3FFE]), 16'h00C0);
		chk(16'(vph_vmem_model_inst.mem[14'h3FFF]), 16'h00C1);
		chk(16'(vph_vmem_model_inst.mem[14'h0000]), 16'h00C2);
		// slow memory: the prefetch must still be ready by the next read
		lat = 4'h3;
		set_addr(14'h3FFE, 1'b0);
		for (int k = 0; k < 3; k++) begin
			xfer(1'b0, 1'b1, 8'h00, q);
			chk(16'(q), 16'(8'hC0 + 8'(k)));
		end
		lat = 4'h0;
		$display("test memory streaming done");
	endtask

	task automatic t_collide();
		// illegal overlap of both strobes: the port must still drive the prefetch and still write
		set_addr(14'h3FFF, 1'b0);
		@(negedge clk);
		port_select = 1'b0;
		host_data_in = 8'h3C;
		repeat (3) @(negedge clk);
		write_strobe_n = 1'b0;
		read_strobe_n = 1'b0;
		repeat (8) @(negedge clk);
		q = host_data_out_q;
		chk(16'(host_data_oe_q), 16'h0001);
		write_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		repeat (328) @(negedge clk);
		chk(16'(q), 16'h00C1);
		chk(16'(vph_vmem_model_inst.mem[14'h0000]), 16'h003C);
		$display("test strobe collision done");
	endtask

	// ==========================================================
	// main sequence
	initial begin
		n_errors = 0;
		n_compared = 0;
		cyc = 0;
		reset_n = 1'b0;
		write_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		port_select = 1'b1;
		host_data_in = 8'h00;
		frame_end = 1'b0;
		sprite_coinc_evt = 1'b0;
		fifth_sprite_evt = 1'b0;
		fifth_sprite_num = 5'h00;
		lat = 4'h0;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		t_reset();
		t_regs();
		t_irq();
		t_pair();
		t_stream();
		t_collide();
		finish_test();
	end
endmodule
